// File: rtl/sptg_pkg.sv
// Package for the spanning-tree port gating and tail-tag block.
// Assumes: one 25 MHz core clock, AXI4-Lite register access, 32-bit data.
package sptg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_GLOBAL1    = 10'h001;
  localparam logic [9:0] IDX_GLOBAL12   = 10'h00C;
  localparam logic [9:0] IDX_PORT1_CTRL = 10'h012;
  localparam logic [9:0] IDX_PORT2_CTRL = 10'h022;
  localparam logic [9:0] IDX_PORT3_CTRL = 10'h032;
  localparam logic [9:0] IDX_PORT4_CTRL = 10'h042;
  localparam logic [9:0] IDX_STATUS     = 10'h0C8;
  localparam int unsigned AXI_ADDR_W    = 12;

  // Per-port control fields
  localparam int unsigned PC_TX_EN_BIT   = 2;
  localparam int unsigned PC_RX_EN_BIT   = 1;
  localparam int unsigned PC_LRN_DIS_BIT = 0;
  localparam logic [7:0]  PORT_CTRL_RST  = 8'h06;

  // Global register fields
  localparam int unsigned G1_FLUSH_DYN_BIT = 5;
  localparam int unsigned G1_FLUSH_STA_BIT = 4;
  localparam logic [7:0]  GLOBAL1_RST      = 8'h00;
  localparam int unsigned G12_TAIL_EN_BIT  = 1;
  localparam logic [7:0]  GLOBAL12_RST     = 8'h00;

  // Tail-tag fields
  localparam int unsigned TAG_BYPASS_BIT = 7;
  localparam int unsigned TAG_FORCE_BIT  = 6;
  localparam int unsigned TAG_QUEUE_LSB  = 4;
  localparam logic [3:0]  TAG_DEST_RSVD  = 4'h0;
  localparam logic [3:0]  TAG_DEST_ALL   = 4'hF;
  localparam int unsigned PROC_PORT_BIT  = 4;
  localparam logic [4:0]  PROC_PORT_MASK = 5'h10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SPTG_DISCARDING,
    SPTG_LEARNING,
    SPTG_FORWARDING,
    SPTG_IRREGULAR
  } sptg_state_t;

  // One frame decision request from the lookup stage
  typedef struct packed {
    logic       valid;
    logic       from_host;
    logic [1:0] src_port;
    logic [4:0] lookup_mask;
    logic       override_hit;
    logic [7:0] tag;
  } sptg_req_t;

  // Registered decision for that frame
  typedef struct packed {
    logic       valid;
    logic [4:0] dest_mask;
    logic       learn;
    logic [1:0] queue;
    logic       directed;
    logic       tag_strip;
    logic       tag_append;
    logic [7:0] tag_out;
  } sptg_res_t;

endpackage

// File: rtl/sptg_port_gate.sv
// Decodes one network port's control byte into gating terms.
// Assumes: control byte comes from the register file in the same clock.
`timescale 1ns/100ps
`default_nettype none
module sptg_port_gate (
  // Control setting
  input  wire logic [7:0]          ctrl,
  // Gating terms
  output logic                     tx_ok,
  output logic                     rx_ok,
  output logic                     learn_ok,
  output sptg_pkg::sptg_state_t    state
);

  always_comb begin
    tx_ok    = ctrl[sptg_pkg::PC_TX_EN_BIT];
    rx_ok    = ctrl[sptg_pkg::PC_RX_EN_BIT];
    learn_ok = ~ctrl[sptg_pkg::PC_LRN_DIS_BIT];
    unique case ({tx_ok, rx_ok, learn_ok})
      3'b000:  state = sptg_pkg::SPTG_DISCARDING;
      3'b001:  state = sptg_pkg::SPTG_LEARNING;
      3'b111:  state = sptg_pkg::SPTG_FORWARDING;
      default: state = sptg_pkg::SPTG_IRREGULAR;
    endcase
  end

endmodule // sptg_port_gate
`default_nettype wire

// File: rtl/sptg_core.sv
// Spanning-tree port gating and tail-tag handling for a five-port switch.
// Assumes: an AXI4-Lite master, a lookup stage that offers one frame
// decision at a time, and a table engine that acts on flush pulses.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module sptg_core (
  // Clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset,
  // AXI4-Lite write address
  input  wire logic [sptg_pkg::AXI_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [sptg_pkg::AXI_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  // Frame decision request and result
  input  wire sptg_pkg::sptg_req_t                   req,
  output sptg_pkg::sptg_res_t                        res,
  // Address table flush request
  output logic                                       flush_pulse,
  output logic [3:0]                                 flush_ports,
  output logic                                       flush_dynamic,
  output logic                                       flush_static
);

  // Register file
  logic [7:0]  global1;
  logic [7:0]  global12;
  logic [7:0]  port_ctrl [4];

  // Write channel holding state
  logic [9:0]  wr_index;
  logic [31:0] wr_data;
  logic        wr_strb0;
  logic        wr_go;
  logic        wr_hit;

  // Decoded per-port terms
  logic [3:0]             tx_ok;
  logic [3:0]             rx_ok;
  logic [3:0]             learn_ok;
  sptg_pkg::sptg_state_t  port_state [4];

  logic        tail_on;
  logic [31:0] rd_value;
  logic        rd_hit;
  logic [7:0]  status_byte;

  logic [4:0]  src_bit;
  sptg_pkg::sptg_res_t next_res;

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      sptg_port_gate u_gate (
        .ctrl     (port_ctrl[gp]),
        .tx_ok    (tx_ok[gp]),
        .rx_ok    (rx_ok[gp]),
        .learn_ok (learn_ok[gp]),
        .state    (port_state[gp])
      );
    end
  endgenerate

  assign tail_on = global12[sptg_pkg::G12_TAIL_EN_BIT];

  // Both halves of a write are held until each has been taken once
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always_comb begin
    unique case (wr_index)
      sptg_pkg::IDX_GLOBAL1,
      sptg_pkg::IDX_GLOBAL12,
      sptg_pkg::IDX_PORT1_CTRL,
      sptg_pkg::IDX_PORT2_CTRL,
      sptg_pkg::IDX_PORT3_CTRL,
      sptg_pkg::IDX_PORT4_CTRL: wr_hit = 1'b1;
      default:                  wr_hit = 1'b0;
    endcase
  end

  // Write address channel
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      wr_index      <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_index      <= s_axi_awaddr[11:2];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_wready <= 1'b1;
      wr_data      <= 32'h0000_0000;
      wr_strb0     <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data      <= s_axi_wdata;
      wr_strb0     <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sptg_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? sptg_pkg::RESP_OKAY : sptg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register storage; only the low byte lane carries data
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      global1  <= sptg_pkg::GLOBAL1_RST;
      global12 <= sptg_pkg::GLOBAL12_RST;
      for (int i = 0; i < 4; i++) begin
        port_ctrl[i] <= sptg_pkg::PORT_CTRL_RST;
      end
    end else if (wr_go && wr_strb0) begin
      unique case (wr_index)
        sptg_pkg::IDX_GLOBAL1:    global1      <= wr_data[7:0];
        sptg_pkg::IDX_GLOBAL12:   global12     <= wr_data[7:0];
        sptg_pkg::IDX_PORT1_CTRL: port_ctrl[0] <= wr_data[7:0];
        sptg_pkg::IDX_PORT2_CTRL: port_ctrl[1] <= wr_data[7:0];
        sptg_pkg::IDX_PORT3_CTRL: port_ctrl[2] <= wr_data[7:0];
        sptg_pkg::IDX_PORT4_CTRL: port_ctrl[3] <= wr_data[7:0];
        default: ;
      endcase
    end
  end

  // Flush issue: one pulse per write that sets both flush bits.
  // Ports taken are those whose learning is disabled at that moment.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flush_pulse   <= 1'b0;
      flush_ports   <= 4'h0;
      flush_dynamic <= 1'b0;
      flush_static  <= 1'b0;
    end else if (wr_go && wr_strb0 && (wr_index == sptg_pkg::IDX_GLOBAL1) &&
                 wr_data[sptg_pkg::G1_FLUSH_DYN_BIT] &&
                 wr_data[sptg_pkg::G1_FLUSH_STA_BIT]) begin
      flush_pulse   <= 1'b1;
      flush_ports   <= ~learn_ok;
      flush_dynamic <= 1'b1;
      flush_static  <= 1'b1;
    end else begin
      flush_pulse   <= 1'b0;
      flush_dynamic <= 1'b0;
      flush_static  <= 1'b0;
    end
  end

  // Status byte shows the decoded state of each port, two bits each
  always_comb begin
    status_byte = {port_state[3], port_state[2], port_state[1], port_state[0]};
  end

  always_comb begin
    rd_hit   = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (s_axi_araddr[11:2])
      sptg_pkg::IDX_GLOBAL1:    rd_value[7:0] = global1;
      sptg_pkg::IDX_GLOBAL12:   rd_value[7:0] = global12;
      sptg_pkg::IDX_PORT1_CTRL: rd_value[7:0] = port_ctrl[0];
      sptg_pkg::IDX_PORT2_CTRL: rd_value[7:0] = port_ctrl[1];
      sptg_pkg::IDX_PORT3_CTRL: rd_value[7:0] = port_ctrl[2];
      sptg_pkg::IDX_PORT4_CTRL: rd_value[7:0] = port_ctrl[3];
      sptg_pkg::IDX_STATUS:     rd_value[7:0] = status_byte;
      default:                  rd_hit        = 1'b0;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sptg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_hit ? sptg_pkg::RESP_OKAY : sptg_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  assign src_bit = 5'h01 << req.src_port;

  // Frame decision
  always_comb begin
    next_res           = '0;
    next_res.valid     = req.valid;
    if (req.from_host) begin
      next_res.learn     = 1'b1;
      next_res.tag_strip = tail_on;
      if (tail_on && !req.tag[sptg_pkg::TAG_BYPASS_BIT] &&
          (req.tag[3:0] != sptg_pkg::TAG_DEST_RSVD)) begin
        // Directed sending ignores port state and lookup alike
        next_res.dest_mask = {1'b0, req.tag[3:0]};
        next_res.queue     = req.tag[sptg_pkg::TAG_QUEUE_LSB +: 2];
        next_res.directed  = 1'b1;
      end else begin
        // Bypass bit or reserved destination falls back to lookup
        next_res.dest_mask = {1'b0, req.lookup_mask[3:0] & tx_ok};
      end
    end else begin
      next_res.learn = learn_ok[req.src_port];
      if (rx_ok[req.src_port]) begin
        // Peer ports only receive if their transmit is enabled
        next_res.dest_mask = req.lookup_mask & {1'b1, tx_ok} & ~src_bit;
      end else begin
        // Receive off: nothing but processor-bound frames leave the port
        next_res.dest_mask = req.lookup_mask & sptg_pkg::PROC_PORT_MASK;
      end
      if (req.override_hit) begin
        next_res.dest_mask[sptg_pkg::PROC_PORT_BIT] = 1'b1;
      end
      // Tag goes only toward the processor port, carrying the ingress port
      next_res.tag_append = tail_on & next_res.dest_mask[sptg_pkg::PROC_PORT_BIT];
      if (next_res.tag_append) begin
        next_res.tag_out = {6'h00, req.src_port};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      res <= '0;
    end else begin
      res <= next_res;
    end
  end

endmodule // sptg_core
`default_nettype wire

// File: test/sptg_core_checker.sv
// Concurrent checks on the gating core's ports.
// Assumes: bound into every sptg_core instance.
`timescale 1ns/100ps
`default_nettype none
module sptg_core_checker (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                reset,
  // Write handshakes
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  // Frame decisions and flush
  input wire sptg_pkg::sptg_req_t req,
  input wire sptg_pkg::sptg_res_t res,
  input wire logic                flush_pulse,
  input wire logic                flush_dynamic,
  input wire logic                flush_static
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_directed;
    req.valid && req.from_host && !req.tag[7] && req.tag[3:0] != 4'h0 ##1 res.directed;
  endsequence
  a_res_follows: assert property (res.valid == $past(req.valid))
    else $error("result valid not one cycle behind request");
  a_directed_dest: assert property (s_directed |->
    res.dest_mask == {1'b0, $past(req.tag[3:0])} && res.queue == $past(req.tag[5:4]))
    else $error("directed frame dest or queue wrong");
  a_bypass_lookup: assert property (req.valid && req.from_host && req.tag[7]
    |=> !res.directed && res.queue == 2'h0) else $error("bypass tag not ignored");
  a_override_proc: assert property (req.valid && !req.from_host && req.override_hit
    |=> res.dest_mask[4]) else $error("override frame missed processor");
  a_tag_source: assert property (req.valid && !req.from_host |=> !res.tag_append
    || res.tag_out == {6'h00, $past(req.src_port)}) else $error("egress tag wrong");
  a_tag_proc_only: assert property (res.tag_append |-> res.dest_mask[4])
    else $error("tag appended without processor port");
  a_flush_at_b: assert property (flush_pulse |-> $rose(s_axi_bvalid)
    && flush_dynamic && flush_static) else $error("flush pulse misplaced");
  a_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
endmodule // sptg_core_checker
bind sptg_core sptg_core_checker u_sptg_core_checker (.ref_clk, .reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .req, .res, .flush_pulse, .flush_dynamic, .flush_static);
`default_nettype wire

// File: test/sptg_host_model.sv
// Host processor on the processor port, merged with network frames.
// Assumes: bench drives commands just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module sptg_host_model (
  // Host commands
  input  wire logic                host_go,
  input  wire logic [7:0]          host_tag,
  input  wire logic [4:0]          host_lookup,
  input  wire logic [3:0]          port_open,
  // Frames toward and from the core
  input  wire sptg_pkg::sptg_req_t net_req,
  input  wire sptg_pkg::sptg_res_t res,
  output sptg_pkg::sptg_req_t      req,
  output logic                     host_took
);
  always_comb begin
    req = net_req;
    // Directed frames toward a closed port are never sent
    if (host_go && (host_tag[7] || (host_tag[3:0] & ~port_open) == 4'h0))
      req = '{1'b1, 1'b1, 2'd0, host_lookup, 1'b0, host_tag};
  end
  assign host_took = res.valid && res.tag_append && port_open[res.tag_out[1:0]];
endmodule // sptg_host_model
`default_nettype wire

// File: test/sptg_core_test.sv
// Self-checking bench for the gating and tail-tag core.
// Assumes: host model feeds req; registers reached over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module sptg_core_test;
  localparam logic [1:0] OK = sptg_pkg::RESP_OKAY;
  localparam logic [1:0] ER = sptg_pkg::RESP_SLVERR;
  logic ref_clk = 1'b0, reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, flush_pulse, flush_dynamic, flush_static;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] flush_ports, port_open = 4'hF;
  logic [7:0] host_tag = 8'h00;
  logic [4:0] host_lookup = 5'h00;
  logic host_go = 1'b0, tail = 1'b0, took;
  logic [2:0] fl;
  sptg_pkg::sptg_req_t req, net_req = '0;
  sptg_pkg::sptg_res_t res;
  int fails = 0, checked = 0;
  always #20 ref_clk = ~ref_clk;
  sptg_host_model u_sptg_host_model (.host_go, .host_tag, .host_lookup, .port_open,
    .net_req, .res, .req, .host_took(took));
  sptg_core u_sptg_core (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req, .res,
    .flush_pulse, .flush_ports, .flush_dynamic, .flush_static);
  function automatic logic [9:0] pidx(input int p);
    return sptg_pkg::IDX_PORT1_CTRL + 10'(16 * p);
  endfunction
  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    fl = {flush_pulse, flush_dynamic, flush_static};
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic axi_rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rdata", {24'h00_0000, e}, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  task automatic fr(input logic h, input logic [1:0] s, input logic [4:0] lk, input logic ov,
    input logic [7:0] tg, input logic [4:0] d, input logic l, input logic [1:0] q,
    input logic dir);
    sptg_pkg::sptg_res_t exp;
    logic ap;
    ap = tail & d[4] & !h;
    exp = '{1'b1, d, l, q, dir, h & tail, ap, ap ? {6'h00, s} : 8'h00};
    @(posedge ref_clk);
    if (h) begin
      host_go <= 1'b1;
      host_tag <= tg;
      host_lookup <= lk;
    end else begin
      net_req <= '{1'b1, 1'b0, s, lk, ov, 8'h00};
    end
    @(posedge ref_clk);
    host_go <= 1'b0;
    net_req <= '0;
    #1;
    `CHK("res", exp, res)
  endtask
  task automatic t_regs;
    for (int p = 0; p < 4; p++) axi_rd(pidx(p), 8'h06, OK);
    axi_rd(sptg_pkg::IDX_GLOBAL12, 8'h00, OK);
    axi_rd(10'h0FF, 8'h00, ER);
    axi_wr(10'h0FF, 8'h5A, ER);
    axi_wr(sptg_pkg::IDX_STATUS, 8'h00, ER);
    axi_rd(sptg_pkg::IDX_STATUS, 8'hAA, OK);
  endtask
  task automatic t_states;
    logic [7:0] cfg [3] = '{8'h01, 8'h00, 8'h06};
    logic [1:0] st [3] = '{2'd0, 2'd1, 2'd2};
    int o;
    for (int p = 0; p < 4; p++) begin
      o = (p + 1) % 4;
      for (int k = 0; k < 3; k++) begin
        axi_wr(pidx(p), cfg[k], OK);
        axi_rd(pidx(p), cfg[k], OK);
        axi_rd(sptg_pkg::IDX_STATUS, (8'hAA & ~(8'h03 << (2 * p))) | (8'(st[k]) << (2 * p)), OK);
        fr(1'b0, 2'(p), 5'h1F, 1'b0, 8'h00, cfg[k][1] ? 5'h1F & ~(5'h01 << p) : 5'h10,
           !cfg[k][0], 2'd0, 1'b0);
        fr(1'b0, 2'(o), 5'h0F, 1'b0, 8'h00, 5'h0F & ~(5'h01 << o) &
           (cfg[k][2] ? 5'h1F : ~(5'h01 << p)), 1'b1, 2'd0, 1'b0);
      end
    end
  endtask
  task automatic t_override;
    // Tail tag on so the host can tell which port an override frame came from
    axi_wr(sptg_pkg::IDX_GLOBAL12, 8'h02, OK);
    tail = 1'b1;
    axi_wr(pidx(0), 8'h01, OK);
    port_open <= 4'hE;
    fr(1'b0, 2'd0, 5'h00, 1'b1, 8'h00, 5'h10, 1'b0, 2'd0, 1'b0);
    `CHK("host_took", 1'b0, took)
    fr(1'b0, 2'd1, 5'h00, 1'b1, 8'h00, 5'h10, 1'b1, 2'd0, 1'b0);
    `CHK("host_took", 1'b1, took)
    axi_wr(pidx(0), 8'h06, OK);
    port_open <= 4'hF;
    axi_wr(sptg_pkg::IDX_GLOBAL12, 8'h00, OK);
    tail = 1'b0;
  endtask
  task automatic t_tail;
    logic [3:0] code [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
    axi_wr(sptg_pkg::IDX_GLOBAL12, 8'h02, OK);
    axi_rd(sptg_pkg::IDX_GLOBAL12, 8'h02, OK);
    tail = 1'b1;
    for (int p = 0; p < 4; p++) axi_wr(pidx(p), 8'h00, OK);
    for (int i = 0; i < 10; i++)
      fr(1'b1, 2'd0, 5'h00, 1'b0, {1'b0, i >= 5, 2'(i), code[i % 5]}, {1'b0, code[i % 5]},
         1'b1, 2'(i), 1'b1);
    for (int p = 0; p < 4; p++) axi_wr(pidx(p), 8'h06, OK);
    fr(1'b1, 2'd0, 5'h0F, 1'b0, 8'hF1, 5'h0F, 1'b1, 2'd0, 1'b0);
    fr(1'b1, 2'd0, 5'h05, 1'b0, 8'h30, 5'h05, 1'b1, 2'd0, 1'b0);
    for (int s = 0; s < 4; s++)
      fr(1'b0, 2'(s), 5'h10, 1'b0, 8'h00, 5'h10, 1'b1, 2'd0, 1'b0);
    axi_wr(sptg_pkg::IDX_GLOBAL12, 8'h00, OK);
    tail = 1'b0;
    fr(1'b1, 2'd0, 5'h04, 1'b0, 8'h01, 5'h04, 1'b1, 2'd0, 1'b0);
    fr(1'b0, 2'd3, 5'h10, 1'b0, 8'h00, 5'h10, 1'b1, 2'd0, 1'b0);
  endtask
  task automatic t_flush;
    axi_wr(pidx(1), 8'h01, OK);
    axi_wr(sptg_pkg::IDX_GLOBAL1, 8'h30, OK);
    `CHK("flush", 3'b111, fl)
    axi_wr(sptg_pkg::IDX_GLOBAL1, 8'h10, OK);
    `CHK("flush", 3'b000, fl)
    `CHK("flush_ports", 4'h2, flush_ports)
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    t_states;
    t_override;
    t_tail;
    t_flush;
    final_report;
  end
  // Whole run needs about 300 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    final_report;
  end
endmodule // sptg_core_test
`default_nettype wire
